// [tb/bsr_host_model.sv]
// Purpose: Serial host in mode 0, one command per frame
// Assumes: 125 ns serial clock period
// Notes: Clock stands still outside frames
module bsr_host_model (
  // Pins
  output logic sclk_o,
  output logic sdi_o,
  output logic csn_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] rx;
  event fin;

  initial
  begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    csn_o = 1'b1;
    rx = 24'h0;
  end

  // Command byte MSB first, then n reply bits on rising edges
  task automatic xfer(input logic [7:0] cmd, input int n);
    int i;
    csn_o = 1'b0;
    rx = 24'h0;
    #62.5;
    for (i = 0; i < 8 + n; i++)
    begin
      sdi_o = (i < 8) ? cmd[7 - i] : ~sdi_o;
      #62.5 sclk_o = 1'b1;
      if (i >= 8)
        rx = {rx[22:0], sdo_i};
      #62.5 sclk_o = 1'b0;
    end
    #62.5 csn_o = 1'b1;
    sdi_o = ~sdi_o;
    if (n > 0)
      -> fin;
  endtask : xfer
endmodule : bsr_host_model

// [tb/bsr_readout_properties.sv]
// Purpose: Port-level properties of the sensor readout
// Assumes: One reference clock domain
// Notes: Bound to every bsr_readout instance
module bsr_readout_checker
  import bsr_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYC = 20
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic serial_in_pin_i,
  input wire logic serial_in_pin_o,
  input wire logic serial_in_pin_oe_o,
  input wire logic select_pin_low_active_n_i,
  input wire logic protocol_select_pin_i,
  input wire logic serial_out_pin_o,
  // Front end and status
  input wire logic [127:0] fuse_words_i,
  input wire logic [23:0] adc_pressure_i,
  input wire logic [23:0] adc_temp_i,
  input wire logic conv_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] busy_cnt;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i || !conv_busy_o)
      busy_cnt <= 16'h0;
    else
      busy_cnt <= busy_cnt + 16'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_quiet_a:
    assert property (disable iff (1'b0) sys_rst_i |=> !conv_busy_o && !serial_out_pin_o && !serial_in_pin_oe_o)
    else $error("outputs active after reset");
  sda_low_drive_a:
    assert property (!serial_in_pin_o) else $error("open drain value not low");
  spi_no_sda_a:
    assert property (!protocol_select_pin_i && !$past(protocol_select_pin_i, 8) |-> !serial_in_pin_oe_o)
    else $error("data line pulled in serial peripheral mode");
  sdo_idle_a:
    assert property (select_pin_low_active_n_i [*8] |-> !serial_out_pin_o)
    else $error("data out driven while deselected");
  i2c_sdo_quiet_a:
    assert property (protocol_select_pin_i [*8] |-> !serial_out_pin_o)
    else $error("data out driven in two-wire mode");
  conv_bound_a:
    assert property (conv_busy_o |-> busy_cnt <= (CONV_BASE_CYC << 4) + 4)
    else $error("conversion overran longest ratio");
  conv_runs_a:
    assert property ($rose(conv_busy_o) |=> conv_busy_o [*8]) else $error("conversion ended at once");
  sdo_edge_a:
    assert property ($changed(serial_out_pin_o) |-> $past(sclk_i, 6) != sclk_i
      || $past(select_pin_low_active_n_i, 6) != select_pin_low_active_n_i)
    else $error("data out moved without clock edge");
endmodule : bsr_readout_checker

bind bsr_readout bsr_readout_checker #(.CONV_BASE_CYC(CONV_BASE_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .serial_in_pin_i(serial_in_pin_i),
  .serial_in_pin_o(serial_in_pin_o), .serial_in_pin_oe_o(serial_in_pin_oe_o),
  .select_pin_low_active_n_i(select_pin_low_active_n_i), .protocol_select_pin_i(protocol_select_pin_i),
  .serial_out_pin_o(serial_out_pin_o), .fuse_words_i(fuse_words_i), .adc_pressure_i(adc_pressure_i),
  .adc_temp_i(adc_temp_i), .conv_busy_o(conv_busy_o));

// [tb/tb.sv]
// Purpose: Self-checking bench for the sensor readout
// Assumes: Serial peripheral mode for traffic
// Notes: Short conversions via CONV_BASE_CYC
module tb;
  import bsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned CB = 20;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ps = 1'b0;
  logic [127:0] fuse = 128'h0;
  logic [23:0] adp = 24'h0;
  logic [23:0] adt = 24'h0;
  logic [7:0] c;
  logic [23:0] exp_q[$];
  wire sclk, serial_in_pin, csn, serial_out_pin, so, oe, busy, sda;
  int fail_count = 0;
  int checked = 0;

  initial forever #5 ref_clk_i = ~ref_clk_i;
  assign sda = oe ? 1'b0 : serial_in_pin;

  bsr_host_model i_host (.sclk_o(sclk), .sdi_o(serial_in_pin), .csn_o(csn), .sdo_i(serial_out_pin));
  bsr_readout #(.CONV_BASE_CYC(CB)) i_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .serial_in_pin_i(sda),
    .serial_in_pin_o(so), .serial_in_pin_oe_o(oe), .select_pin_low_active_n_i(csn),
    .protocol_select_pin_i(ps), .serial_out_pin_o(serial_out_pin), .fuse_words_i(fuse),
    .adc_pressure_i(adp), .adc_temp_i(adt), .conv_busy_o(busy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task wait_idle;
    int i;
    for (i = 0; i < 4000 && busy !== 1'b0; i++)
      cyc(1);
    if (busy !== 1'b0)
    begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_idle

  task rd(input logic [7:0] cmd, input int n, input logic [23:0] exp);
    exp_q.push_back(exp);
    i_host.xfer(cmd, n);
    cyc(4);
  endtask : rd

  task cmd_only(input logic [7:0] cmd);
    i_host.xfer(cmd, 0);
    cyc(4);
  endtask : cmd_only

  // ----------------------------------------
  // Reply watcher
  // ----------------------------------------
  always @(i_host.fin)
  begin
    if (exp_q.size() == 0)
      fail_count++;
    else
      check(i_host.rx, exp_q.pop_front());
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(10));
    fuse = {$urandom(), $urandom(), $urandom(), $urandom()};
    cyc(10);
    sys_rst_i = 1'b0;
    cyc(4);
    rd(8'hA2, 16, 24'h0);
    cmd_only(8'h1E);
    for (int a = 0; a < 8; a++)
      rd(8'hA0 | 8'(a << 1), 16, {8'h00, fuse[16 * a +: 16]});
    rd(8'h00, 24, 24'h0);
    for (int k = 0; k < 10; k++)
    begin
      c = (k < 5 ? 8'h40 : 8'h50) + 8'(2 * (k % 5));
      adp = 24'($urandom());
      adt = 24'($urandom());
      cmd_only(c);
      check({23'h0, busy}, 24'h1);
      wait_idle();
      rd(8'h00, 24, c[4] ? adt : adp);
      rd(8'h00, 24, 24'h0);
    end
    adp = 24'($urandom());
    cmd_only(8'h48);
    rd(8'h00, 24, 24'h0);
    wait_idle();
    rd(8'h00, 24, adp ^ 24'hFFFFFF);
    fuse = {$urandom(), $urandom(), $urandom(), $urandom()};
    cmd_only(8'h58);
    cmd_only(8'h1E);
    check({23'h0, busy}, 24'h0);
    rd(8'hAE, 16, {8'h00, fuse[127:112]});
    rd(8'h00, 24, 24'h0);
    ps = 1'b1;
    cyc(20);
    check({22'h0, oe, serial_out_pin}, 24'h0);
    ps = 1'b0;
    cyc(20);
    if (exp_q.size() != 0)
      fail_count++;
    give_verdict();
  end
endmodule : tb

// [verilog/bsr_consts.svh]
// Purpose: Shared constants for the barometric sensor readout
// Assumes: 100 MHz reference clock
// Notes: Command codes, pin indices, timing
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define BSR_CMD_RESET 8'h1E
`define BSR_CMD_ADC_READ 8'h00
`define BSR_CMD_CONV_P 3'h2
`define BSR_CMD_CALIBRATION_MEMORY_HI 4'hA
`define BSR_OSR_MAX 3'h4

// ----------------------------------------
// I2C address
// ----------------------------------------
`define BSR_I2C_ADDR_HI 6'h3B

// ----------------------------------------
// Synchronised pin indices
// ----------------------------------------
`define BSR_PIN_SCLK 0
`define BSR_PIN_SDI 1
`define BSR_PIN_CSN 2
`define BSR_PIN_PS 3

// ----------------------------------------
// Timing and corruption mask
// ----------------------------------------
`define BSR_CLK_NS 10
`define BSR_CONV_BASE_NS 60000
`define BSR_CORRUPT_MASK 24'hFFFFFF

`endif

// [verilog/bsr_conv.sv]
// Purpose: Raw conversion sequencer and result holder
// Assumes: Front-end samples are stable when a conversion ends
// Notes: Conversion time doubles with each oversampling step
`include "bsr_consts.svh"

module bsr_conv
  import bsr_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYC = `BSR_CONV_BASE_NS / `BSR_CLK_NS
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Requests
  input wire bsr_conv_req_t req_i,
  // Front end
  input wire logic [23:0] adc_pressure_i,
  input wire logic [23:0] adc_temp_i,
  // Result
  output bsr_adc_t adc_o
);

  bsr_conv_st_t r;
  bsr_conv_st_t next_r;
  logic hit;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    hit = r.corrupt | req_i.read;
    if (req_i.start)
    begin
      next_r.corrupt = r.busy;
      next_r.busy = 1'b1;
      next_r.valid = 1'b0;
      next_r.kind = req_i.kind;
      next_r.cnt = 32'(CONV_BASE_CYC) << req_i.oversampling_ratio;
    end
    else if (r.busy)
    begin
      if (req_i.read)
        next_r.corrupt = 1'b1;
      if (r.cnt <= 32'h1)
      begin
        next_r.busy = 1'b0;
        next_r.valid = 1'b1;
        // Wrong on purpose: a mid-conversion read disturbs the modulator
        next_r.data = (r.kind ? adc_temp_i : adc_pressure_i) ^ (hit ? `BSR_CORRUPT_MASK : 24'h000000);
      end
      else
        next_r.cnt = r.cnt - 32'h1;
    end
    else if (req_i.read)
      next_r.valid = 1'b0;
    if (req_i.abort)
    begin
      next_r.busy = 1'b0;
      next_r.valid = 1'b0;
      next_r.corrupt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign adc_o.busy = r.busy;
  assign adc_o.valid = r.valid;
  assign adc_o.data = r.data;

endmodule : bsr_conv

// [verilog/bsr_pkg.sv]
// Purpose: Types for the barometric sensor readout
// Assumes: Nothing beyond the constants header
// Notes: State structs follow the one-struct idiom
package bsr_pkg;

  // ----------------------------------------
  // Link state and command classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    BSR_ST_IDLE = 3'b000,
    BSR_ST_ADDR = 3'b001,
    BSR_ST_CMD = 3'b010,
    BSR_ST_ACK_OUT = 3'b011,
    BSR_ST_TX = 3'b100,
    BSR_ST_ACK_IN = 3'b101,
    BSR_ST_IGNORE = 3'b110
  } bsr_state_t;

  typedef enum logic [2:0] {
    BSR_C_NONE = 3'b000,
    BSR_C_RESET = 3'b001,
    BSR_C_CONV = 3'b010,
    BSR_C_ADC = 3'b011,
    BSR_C_CALIBRATION_MEMORY = 3'b100
  } bsr_cmd_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic start;
    logic kind;
    logic [2:0] oversampling_ratio;
    logic read;
    logic abort;
  } bsr_conv_req_t;

  typedef struct packed {
    logic busy;
    logic valid;
    logic [23:0] data;
  } bsr_adc_t;

  // ----------------------------------------
  // Module state
  // ----------------------------------------
  typedef struct packed {
    logic busy;
    logic valid;
    logic corrupt;
    logic kind;
    logic [31:0] cnt;
    logic [23:0] data;
  } bsr_conv_st_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] pin;
    bsr_state_t st;
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [23:0] tx;
    logic skip;
    logic ack_due;
    logic rd;
    logic hold;
    logic sda_oe;
    logic so;
    logic [7:0][15:0] cal;
  } bsr_main_st_t;

endpackage : bsr_pkg

// [verilog/bsr_readout.sv]
// Purpose: Command decoder and serial readout for the pressure sensor
// Assumes: Serial clock far slower than ref_clk_i (125 ns period)
// Notes: SPI modes 0 and 3, or I2C, chosen by the protocol pin
`include "bsr_consts.svh"

module bsr_readout
  import bsr_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYC = `BSR_CONV_BASE_NS / `BSR_CLK_NS
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  input wire logic select_pin_low_active_n_i,
  input wire logic protocol_select_pin_i,
  output logic serial_out_pin_o,
  // Factory fuses and analog front end
  input wire logic [127:0] fuse_words_i,
  input wire logic [23:0] adc_pressure_i,
  input wire logic [23:0] adc_temp_i,
  // Status
  output logic conv_busy_o
);

  bsr_main_st_t r;
  bsr_main_st_t next_r;
  bsr_conv_req_t req;
  bsr_adc_t adc;
  logic [3:0] raw;
  logic rise;
  logic fall;
  logic is_i2c;
  logic i2c_start;
  logic i2c_stop;
  logic [7:0] byte_in;

  // ----------------------------------------
  // Command classification
  // ----------------------------------------
  function automatic bsr_cmd_t classify(input logic [7:0] c);
    bsr_cmd_t k;
    k = BSR_C_NONE;
    if (c == `BSR_CMD_RESET)
      k = BSR_C_RESET;
    else if (c == `BSR_CMD_ADC_READ)
      k = BSR_C_ADC;
    else if (c[7:5] == `BSR_CMD_CONV_P && !c[0] && c[3:1] <= `BSR_OSR_MAX)
      k = BSR_C_CONV;
    else if (c[7:4] == `BSR_CMD_CALIBRATION_MEMORY_HI && !c[0])
      k = BSR_C_CALIBRATION_MEMORY;
    return k;
  endfunction : classify

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  bsr_conv #(
    .CONV_BASE_CYC(CONV_BASE_CYC)
  ) u_conv (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req),
    .adc_pressure_i(adc_pressure_i),
    .adc_temp_i(adc_temp_i),
    .adc_o(adc)
  );

  assign raw = {protocol_select_pin_i, select_pin_low_active_n_i, serial_in_pin_i, sclk_i};

  // ----------------------------------------
  // Link engine
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    req = '0;
    next_r.s1 = raw;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A level counts only once two late stages agree
    for (int i = 0; i < 4; i++)
    begin
      if (r.s2[i] == r.s3[i])
        next_r.pin[i] = r.s3[i];
    end
    rise = next_r.pin[`BSR_PIN_SCLK] & ~r.pin[`BSR_PIN_SCLK];
    fall = ~next_r.pin[`BSR_PIN_SCLK] & r.pin[`BSR_PIN_SCLK];
    is_i2c = r.pin[`BSR_PIN_PS];
    i2c_start = is_i2c & r.pin[`BSR_PIN_SCLK] & next_r.pin[`BSR_PIN_SCLK]
      & r.pin[`BSR_PIN_SDI] & ~next_r.pin[`BSR_PIN_SDI];
    i2c_stop = is_i2c & r.pin[`BSR_PIN_SCLK] & next_r.pin[`BSR_PIN_SCLK]
      & ~r.pin[`BSR_PIN_SDI] & next_r.pin[`BSR_PIN_SDI];
    byte_in = {r.rx[6:0], next_r.pin[`BSR_PIN_SDI]};

    if (rise)
      next_r.rx = byte_in;

    // Command byte complete
    if (rise && r.st == BSR_ST_CMD)
    begin
      next_r.cnt = r.cnt + 3'h1;
      if (r.cnt == 3'h7)
      begin
        next_r.tx = 24'h000000;
        case (classify(byte_in))
          BSR_C_RESET:
          begin
            next_r.cal = fuse_words_i;
            req.abort = 1'b1;
          end
          BSR_C_CONV:
          begin
            req.start = 1'b1;
            req.kind = byte_in[4];
            req.oversampling_ratio = byte_in[3:1];
          end
          BSR_C_ADC:
          begin
            req.read = 1'b1;
            if (adc.valid && !adc.busy)
              next_r.tx = adc.data;
          end
          BSR_C_CALIBRATION_MEMORY:
            next_r.tx = {r.cal[byte_in[3:1]], 8'h00};
          default:
            next_r.tx = 24'h000000;
        endcase
        if (is_i2c)
          next_r.ack_due = 1'b1;
        else
        begin
          next_r.st = BSR_ST_TX;
          next_r.skip = 1'b1;
        end
      end
    end

    if (!is_i2c)
    begin
      // SPI: select frames the transfer only, conversions run on regardless
      if (r.pin[`BSR_PIN_CSN])
      begin
        next_r.st = BSR_ST_IDLE;
        next_r.cnt = 3'h0;
      end
      else if (r.st == BSR_ST_IDLE)
        next_r.st = BSR_ST_CMD;
      else if (fall && r.st == BSR_ST_TX)
      begin
        // First falling edge after the command is skipped for mode 0
        if (r.skip)
          next_r.skip = 1'b0;
        else
          next_r.tx = {r.tx[22:0], 1'b0};
      end
      next_r.sda_oe = 1'b0;
    end
    else if (i2c_start)
    begin
      next_r.st = BSR_ST_ADDR;
      next_r.cnt = 3'h0;
      next_r.sda_oe = 1'b0;
      next_r.ack_due = 1'b0;
    end
    else if (i2c_stop)
    begin
      next_r.st = BSR_ST_IDLE;
      next_r.sda_oe = 1'b0;
      next_r.ack_due = 1'b0;
    end
    else if (fall && r.ack_due)
    begin
      next_r.ack_due = 1'b0;
      next_r.sda_oe = 1'b1;
      next_r.st = BSR_ST_ACK_OUT;
    end
    else
    begin
      case (r.st)
        BSR_ST_ADDR:
          if (rise)
          begin
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h7)
            begin
              if (byte_in[7:1] == {`BSR_I2C_ADDR_HI, ~r.pin[`BSR_PIN_CSN]})
              begin
                next_r.ack_due = 1'b1;
                next_r.rd = byte_in[0];
              end
              else
                next_r.st = BSR_ST_IGNORE;
            end
          end
        BSR_ST_ACK_OUT:
          if (fall)
          begin
            next_r.cnt = 3'h0;
            if (r.rd)
            begin
              next_r.st = BSR_ST_TX;
              next_r.sda_oe = ~r.tx[23];
            end
            else
            begin
              next_r.st = BSR_ST_CMD;
              next_r.sda_oe = 1'b0;
            end
          end
        BSR_ST_TX:
          if (fall)
          begin
            next_r.tx = {r.tx[22:0], 1'b0};
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == 3'h7)
            begin
              next_r.sda_oe = 1'b0;
              next_r.st = BSR_ST_ACK_IN;
            end
            else
              next_r.sda_oe = ~next_r.tx[23];
          end
        BSR_ST_ACK_IN:
          if (rise)
            next_r.hold = next_r.pin[`BSR_PIN_SDI];
          else if (fall)
          begin
            next_r.cnt = 3'h0;
            if (r.hold)
              next_r.st = BSR_ST_IGNORE;
            else
            begin
              next_r.st = BSR_ST_TX;
              next_r.sda_oe = ~r.tx[23];
            end
          end
        default:
          next_r.sda_oe = 1'b0;
      endcase
    end

    next_r.so = ~is_i2c & (next_r.st == BSR_ST_TX) & next_r.tx[23];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
      r.s1 <= 4'hF;
      r.s2 <= 4'hF;
      r.s3 <= 4'hF;
      r.pin <= 4'hF;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_out_pin_o = r.so;
  assign serial_in_pin_o = 1'b0;
  assign serial_in_pin_oe_o = r.sda_oe;
  assign conv_busy_o = adc.busy;

endmodule : bsr_readout
